// [rpmrc_power_rx.sv]
`timescale 1ns/10ps
module rpmrc_power_rx #(
    parameter int SETTLE_CYC = rpmrc_pkg::RPMRC_SETTLE_CYC // start-up settle wait
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic main_enable_in,
    input wire logic secondary_wake_enable_in,
    input wire logic receiver_input_one_in,
    input wire logic receiver_input_two_in,
    input wire logic tag_response_in,
    input wire logic [rpmrc_pkg::RPMRC_RSSI_WIDTH-1:0] main_rssi_in,
    input wire logic [rpmrc_pkg::RPMRC_RSSI_WIDTH-1:0] aux_rssi_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic regulators_enable_out,
    output logic digital_supply_output_out,
    output logic osc_enable_out,
    output logic mcu_clock_hf_select_out,
    output logic mcu_clock_aux_out,
    output logic tx_enable_out,
    output logic rx_enable_out,
    output logic half_power_out,
    output logic supply_5v_out,
    output logic rf_ready_out,
    output logic main_rx_data_out,
    output logic aux_rx_data_out,
    output logic low_band_filter_select_out,
    output logic mid_band_filter_select_out,
    output logic high_band_filter_select_out,
    output logic wide_band_filter_select_out,
    output logic gain_reduction_bit_high_out,
    output logic gain_reduction_bit_low_out
);
    import rpmrc_pkg::*;

    // pin inputs: bit 0 main enable, 1 wake, 2 rx one, 3 rx two
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    logic [3:0] clean_q; // follows a pin once stages two and three agree
    logic [3:0] clean_d;
    logic wake_prev_q; // registered previous wake level for edge detect
    rpmrc_state_e state_q;
    rpmrc_state_e state_d;
    logic wake_start_q; // start-up was caused by the wake pin
    logic [15:0] cnt_q; // settle or wake window counter
    logic [15:0] recover_q; // rf recovery countdown
    logic [7:0] aux_div_q; // 60 khz divider
    logic [7:0] ctrl_q;
    logic [7:0] proto_q;
    logic [7:0] setting_q;
    logic [2:0] rssi_main_q;
    logic [2:0] rssi_aux_q;
    logic osc_stable_q;
    logic aux_clk_q;
    logic main_rx_q;
    logic aux_rx_q;

    // named decode wires
    wire main_en = clean_q[0];
    wire wake_en = clean_q[1];
    wire wake_rise = clean_q[1] & ~wake_prev_q;
    wire hf_on = (state_q == RPMRC_WAKE_WAIT) | (state_q == RPMRC_ACTIVE);
    wire powered = hf_on | (state_q == RPMRC_STARTUP);
    wire active = (state_q == RPMRC_ACTIVE);
    wire standby = ctrl_q[RPMRC_CTRL_STANDBY_BIT];
    wire rf_on = ctrl_q[RPMRC_CTRL_RF_ON_BIT];
    wire rx_only = ctrl_q[RPMRC_CTRL_RX_ONLY_BIT];
    wire swap = ctrl_q[RPMRC_CTRL_RX_SWAP_BIT];
    wire wr_ctrl = reg_wr_in & (reg_addr_in == RPMRC_CHIP_CTRL_ADDR);
    wire wr_proto = reg_wr_in & (reg_addr_in == RPMRC_PROTO_SEL_ADDR);
    wire wr_setting = reg_wr_in & (reg_addr_in == RPMRC_RX_SETTING_ADDR);
    wire settle_done = (cnt_q == 16'(SETTLE_CYC - 1));
    wire wake_timeout = (cnt_q == 16'(RPMRC_WAKE_CYC - 1));
    wire aux_tick = (aux_div_q == 8'(RPMRC_AUX_HALF_CYC - 1));
    wire [7:0] ctrl_next = wr_ctrl ? reg_wdata_in : ctrl_q;
    // standby recovers in 100 us on any exit, mode 1 in 25 us when going to an rf mode
    wire leave_standby = active & standby & ~ctrl_next[RPMRC_CTRL_STANDBY_BIT];
    wire leave_mode1 = active & ~standby & ~rf_on & ~rx_only
                       & (ctrl_next[RPMRC_CTRL_RF_ON_BIT] | ctrl_next[RPMRC_CTRL_RX_ONLY_BIT]);
    wire [7:0] rd_mux = (reg_addr_in == RPMRC_CHIP_CTRL_ADDR) ? ctrl_q :
                        (reg_addr_in == RPMRC_PROTO_SEL_ADDR) ? proto_q :
                        (reg_addr_in == RPMRC_RX_SETTING_ADDR) ? setting_q :
                        (reg_addr_in == RPMRC_RSSI_OSC_ADDR) ?
                            {1'b0, osc_stable_q, rssi_aux_q, rssi_main_q} :
                        8'h00; // unmapped offsets read as zero

    // a bit changes only once stages two and three agree, filtering glitches
    assign clean_d = (sync2_q & sync3_q) | (clean_q & (sync2_q | sync3_q));

    // three-stage pin synchroniser
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            clean_q <= 4'h0;
            wake_prev_q <= 1'b0;
        end else begin
            sync1_q <= {receiver_input_two_in, receiver_input_one_in,
                        secondary_wake_enable_in, main_enable_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            clean_q <= clean_d;
            wake_prev_q <= clean_q[1];
        end
    end

    // power sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            RPMRC_PWR_DOWN: begin
                if (main_en || wake_rise) begin
                    state_d = RPMRC_STARTUP;
                end
            end
            RPMRC_SLEEP: begin
                if (main_en) begin
                    state_d = RPMRC_STARTUP;
                end else if (!wake_en) begin
                    state_d = RPMRC_PWR_DOWN;
                end
            end
            RPMRC_STARTUP: begin
                if (!main_en && !wake_start_q) begin
                    state_d = wake_en ? RPMRC_SLEEP : RPMRC_PWR_DOWN;
                end else if (settle_done) begin
                    // switch to crystal clock once settled
                    state_d = main_en ? RPMRC_ACTIVE : RPMRC_WAKE_WAIT;
                end
            end
            RPMRC_WAKE_WAIT: begin
                if (main_en) begin
                    state_d = RPMRC_ACTIVE;
                end else if (wake_timeout) begin
                    state_d = RPMRC_PWR_DOWN;
                end
            end
            RPMRC_ACTIVE: begin
                if (!main_en) begin
                    state_d = wake_en ? RPMRC_SLEEP : RPMRC_PWR_DOWN;
                end
            end
            default: state_d = RPMRC_PWR_DOWN;
        endcase
    end

    // sequencer state, counters and oscillator flag
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= RPMRC_PWR_DOWN;
            wake_start_q <= 1'b0;
            cnt_q <= 16'h0000;
            osc_stable_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // counter restarts on every state change
            cnt_q <= (state_d != state_q) ? 16'h0000 : cnt_q + 16'h0001;
            if (state_q == RPMRC_PWR_DOWN) begin
                wake_start_q <= ~main_en;
            end
            if (state_d == RPMRC_PWR_DOWN || state_d == RPMRC_SLEEP) begin
                osc_stable_q <= 1'b0;
            end else if (state_q == RPMRC_STARTUP && state_d != RPMRC_STARTUP) begin
                osc_stable_q <= 1'b1;
            end
        end
    end

    // 60 khz auxiliary clock, runs only while the crystal clock is not out
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aux_div_q <= 8'h00;
            aux_clk_q <= 1'b0;
        end else if (state_q == RPMRC_SLEEP || state_q == RPMRC_STARTUP) begin
            aux_div_q <= aux_tick ? 8'h00 : aux_div_q + 8'h01;
            aux_clk_q <= aux_clk_q ^ aux_tick;
        end else begin
            aux_div_q <= 8'h00;
            aux_clk_q <= 1'b0;
        end
    end

    // rf recovery countdown after leaving a low-power active mode
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            recover_q <= 16'h0000;
        end else if (!active) begin
            recover_q <= 16'h0000;
        end else if (leave_standby) begin
            recover_q <= 16'(RPMRC_STANDBY_CYC);
        end else if (leave_mode1) begin
            recover_q <= 16'(RPMRC_MODE1_CYC);
        end else if (recover_q != 16'h0000) begin
            recover_q <= recover_q - 16'h0001;
        end
    end

    // register file; setting reload has priority over a host write
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= RPMRC_CHIP_CTRL_RST;
            proto_q <= RPMRC_PROTO_SEL_RST;
            setting_q <= RPMRC_RX_SETTING_RST;
            reg_rdata_out <= 8'h00;
        end else begin
            ctrl_q <= ctrl_next;
            if (wr_proto) begin
                proto_q <= reg_wdata_in;
            end
            if (!main_en || wr_proto) begin
                setting_q <= RPMRC_RX_SETTING_RST;
            end else if (wr_setting) begin
                setting_q <= reg_wdata_in & 8'hfc;
            end
            if (reg_rd_in) begin
                reg_rdata_out <= rd_mux; // unmapped reads return zero
            end
        end
    end

    // signal strength capture and receiver steering
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rssi_main_q <= 3'h0;
            rssi_aux_q <= 3'h0;
            main_rx_q <= 1'b0;
            aux_rx_q <= 1'b0;
        end else begin
            if (tag_response_in) begin
                rssi_main_q <= main_rssi_in;
                rssi_aux_q <= aux_rssi_in;
            end
            // both paths are registered and gated by rx enable; swap exchanges them
            main_rx_q <= rx_enable_out & (swap ? clean_q[3] : clean_q[2]);
            aux_rx_q <= rx_enable_out & (swap ? clean_q[2] : clean_q[3]);
        end
    end

    // outputs
    assign regulators_enable_out = powered;
    assign digital_supply_output_out = (state_q != RPMRC_PWR_DOWN);
    assign osc_enable_out = powered;
    assign mcu_clock_hf_select_out = hf_on;
    assign mcu_clock_aux_out = aux_clk_q;
    assign tx_enable_out = active & ~standby & rf_on;
    assign rx_enable_out = active & ~standby & (rf_on | rx_only);
    assign half_power_out = tx_enable_out & ctrl_q[RPMRC_CTRL_HALF_PWR_BIT];
    assign supply_5v_out = ctrl_q[RPMRC_CTRL_SUPPLY_5V_BIT];
    assign rf_ready_out = active & (recover_q == 16'h0000);
    assign main_rx_data_out = main_rx_q;
    assign aux_rx_data_out = aux_rx_q;
    assign low_band_filter_select_out = setting_q[RPMRC_SET_LOW_BAND_BIT];
    assign mid_band_filter_select_out = setting_q[RPMRC_SET_MID_BAND_BIT];
    assign high_band_filter_select_out = setting_q[RPMRC_SET_HIGH_BAND_BIT];
    assign wide_band_filter_select_out = setting_q[RPMRC_SET_WIDE_BAND_BIT];
    assign gain_reduction_bit_high_out = setting_q[RPMRC_SET_GAIN_HI_BIT];
    assign gain_reduction_bit_low_out = setting_q[RPMRC_SET_GAIN_LO_BIT];

    // checks
    main_powers_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == RPMRC_PWR_DOWN && main_en) |=> regulators_enable_out && osc_enable_out)
        else $error("main enable did not start regulators");
    sleep_outputs_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == RPMRC_SLEEP) |-> !tx_enable_out && !rx_enable_out && !osc_enable_out
            && digital_supply_output_out && !mcu_clock_hf_select_out)
        else $error("sleep outputs wrong");
    wake_start_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == RPMRC_PWR_DOWN && wake_rise) |=> (state_q == RPMRC_STARTUP))
        else $error("wake edge did not start up");
    wake_timeout_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(state_q == RPMRC_WAKE_WAIT) ##1 (!main_en) [*8] |-> state_q == RPMRC_WAKE_WAIT)
        else $error("wake window ended early");
    wake_bound_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == RPMRC_WAKE_WAIT && wake_timeout && !main_en) |=> state_q == RPMRC_PWR_DOWN)
        else $error("wake window did not power down");
    switch_flag_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(mcu_clock_hf_select_out) |-> osc_stable_q && $past(state_q) == RPMRC_STARTUP)
        else $error("clock switched without stable flag");
    standby_off_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (active && standby) |-> !tx_enable_out && !rx_enable_out)
        else $error("standby left rf on");
    rx_only_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (active && !standby && rx_only && !rf_on) |-> rx_enable_out && !tx_enable_out)
        else $error("mode 2 wrong");
    half_power_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        half_power_out == (active && !standby && rf_on && ctrl_q[RPMRC_CTRL_HALF_PWR_BIT]))
        else $error("half power does not follow control bits");
    setting_reload_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        wr_proto |=> setting_q == RPMRC_RX_SETTING_RST)
        else $error("setting not reloaded on protocol write");
    osc_clear_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == RPMRC_SLEEP || state_q == RPMRC_PWR_DOWN) |-> !osc_stable_q)
        else $error("oscillator flag set while off");

endmodule // rpmrc_power_rx

// [rpmrc_pkg.sv]
package rpmrc_pkg;

    // register offsets
    localparam logic [7:0] RPMRC_CHIP_CTRL_ADDR = 8'h00;
    localparam logic [7:0] RPMRC_PROTO_SEL_ADDR = 8'h01;
    localparam logic [7:0] RPMRC_RX_SETTING_ADDR = 8'h0a;
    localparam logic [7:0] RPMRC_RSSI_OSC_ADDR = 8'h0f;

    // reset values
    localparam logic [7:0] RPMRC_CHIP_CTRL_RST = 8'h01; // 5 v supply by default
    localparam logic [7:0] RPMRC_PROTO_SEL_RST = 8'h02;
    localparam logic [7:0] RPMRC_RX_SETTING_RST = 8'h40;
    localparam logic [7:0] RPMRC_RSSI_OSC_RST = 8'h00;

    // chip status control field positions
    localparam int RPMRC_CTRL_STANDBY_BIT = 7;
    localparam int RPMRC_CTRL_RF_ON_BIT = 5;
    localparam int RPMRC_CTRL_HALF_PWR_BIT = 4;
    localparam int RPMRC_CTRL_RX_SWAP_BIT = 3;
    localparam int RPMRC_CTRL_RX_ONLY_BIT = 1;
    localparam int RPMRC_CTRL_SUPPLY_5V_BIT = 0;

    // signal strength / oscillator status field positions
    localparam int RPMRC_OSC_STABLE_BIT = 6;
    localparam int RPMRC_RSSI_AUX_LSB = 3;
    localparam int RPMRC_RSSI_MAIN_LSB = 0;
    localparam int RPMRC_RSSI_WIDTH = 3;

    // rx filter and gain setting field positions
    localparam int RPMRC_SET_LOW_BAND_BIT = 7;
    localparam int RPMRC_SET_MID_BAND_BIT = 6;
    localparam int RPMRC_SET_HIGH_BAND_BIT = 5;
    localparam int RPMRC_SET_WIDE_BAND_BIT = 4;
    localparam int RPMRC_SET_GAIN_HI_BIT = 3;
    localparam int RPMRC_SET_GAIN_LO_BIT = 2;

    // timing, core clock at 10 mhz
    localparam int RPMRC_CLK_HZ = 10_000_000;
    localparam int RPMRC_AUX_CLK_HZ = 60_000;
    localparam int RPMRC_SETTLE_TIME_US = 500;
    localparam int RPMRC_WAKE_WINDOW_US = 100;
    localparam int RPMRC_STANDBY_RECOVER_US = 100;
    localparam int RPMRC_MODE1_RECOVER_US = 25;
    // only the aux half period rounds down
    localparam int RPMRC_SETTLE_CYC = RPMRC_SETTLE_TIME_US * (RPMRC_CLK_HZ / 1_000_000);
    localparam int RPMRC_WAKE_CYC = RPMRC_WAKE_WINDOW_US * (RPMRC_CLK_HZ / 1_000_000);
    localparam int RPMRC_STANDBY_CYC = RPMRC_STANDBY_RECOVER_US * (RPMRC_CLK_HZ / 1_000_000);
    localparam int RPMRC_MODE1_CYC = RPMRC_MODE1_RECOVER_US * (RPMRC_CLK_HZ / 1_000_000);
    localparam int RPMRC_AUX_HALF_CYC = RPMRC_CLK_HZ / (2 * RPMRC_AUX_CLK_HZ);

    // power sequencer states
    typedef enum logic [2:0] {
        RPMRC_PWR_DOWN,
        RPMRC_SLEEP,
        RPMRC_STARTUP,
        RPMRC_WAKE_WAIT,
        RPMRC_ACTIVE
    } rpmrc_state_e;

endpackage

// [rpmrc_host_model.sv]
`timescale 1ns/10ps
// host controller model: owns both enable pins and the register strobes
module rpmrc_host_model #(
    parameter int PIN_GAP_CYC = 10_000 // 1 ms between pin changes at 10 mhz
) (
    input wire logic core_clk_in,
    input wire logic [7:0] reg_rdata_in,
    output logic main_enable_out,
    output logic secondary_wake_enable_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out
);
    int cyc = 0; // free running cycle count
    int last_cyc = 0; // cycle of the last pin change
    int last_pin = 0; // which pin moved last: 0 main, 1 wake
    initial begin
        main_enable_out = 1'b0;
        secondary_wake_enable_out = 1'b0;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
    end
    // cycle count for pin spacing
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
    end
    // single byte write, strobe high for exactly one edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_out <= 1'b0;
    endtask
    // single byte read, data taken once the loading edge has landed
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_out <= 1'b0;
        #1;
        d = reg_rdata_in;
    endtask
    // pin change; gap 0 stands for a button pulse that the host does not time
    task automatic set_pin(input int pin, input logic lvl, input int gap);
        while (pin != last_pin && cyc - last_cyc < gap) begin
            @(posedge core_clk_in);
        end
        @(posedge core_clk_in);
        if (pin == 0) begin
            main_enable_out <= lvl;
        end else begin
            secondary_wake_enable_out <= lvl;
        end
        last_cyc = cyc;
        last_pin = pin;
    endtask
endmodule // rpmrc_host_model

// [reader_power_mode_and_rx_config_bench.sv]
`timescale 1ns/10ps
// bench: host model on the pins and registers, bench on rx and rssi inputs
module reader_power_mode_and_rx_config_bench;
    import rpmrc_pkg::*;
    localparam int GAP = 10_000; // 1 ms host spacing
    logic core_clk, reset_n, rx1, rx2, tag;
    logic [2:0] m_rssi, a_rssi;
    logic en, wk, wr, rd, reg_en, dsup, osc_en, hf, aux_clk, tx, rx, half, sup5, rdy;
    logic mrx, arx, lb, mb, hb, wb, gh, gl;
    logic [7:0] addr, wdata, rdata, d;
    int miscompares = 0;
    int compares = 0;
    // grouped views keep the compares short
    wire [7:0] pw_vec = {4'h0, reg_en, osc_en, dsup, hf};
    wire [7:0] rf_vec = {4'h0, tx, rx, half, sup5};
    wire [7:0] rxd_vec = {6'h00, mrx, arx};
    wire [7:0] flt_vec = {lb, mb, hb, wb, gh, gl, 2'b00};
    rpmrc_power_rx #(.SETTLE_CYC(20)) i_dut (.core_clk_in(core_clk), .reset_n_in(reset_n),
        .main_enable_in(en), .secondary_wake_enable_in(wk), .receiver_input_one_in(rx1),
        .receiver_input_two_in(rx2), .tag_response_in(tag), .main_rssi_in(m_rssi),
        .aux_rssi_in(a_rssi), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .regulators_enable_out(reg_en),
        .digital_supply_output_out(dsup), .osc_enable_out(osc_en),
        .mcu_clock_hf_select_out(hf), .mcu_clock_aux_out(aux_clk), .tx_enable_out(tx),
        .rx_enable_out(rx), .half_power_out(half), .supply_5v_out(sup5), .rf_ready_out(rdy),
        .main_rx_data_out(mrx), .aux_rx_data_out(arx), .low_band_filter_select_out(lb),
        .mid_band_filter_select_out(mb), .high_band_filter_select_out(hb),
        .wide_band_filter_select_out(wb), .gain_reduction_bit_high_out(gh),
        .gain_reduction_bit_low_out(gl));
    rpmrc_host_model #(.PIN_GAP_CYC(GAP)) i_host (.core_clk_in(core_clk), .reg_rdata_in(rdata),
        .main_enable_out(en), .secondary_wake_enable_out(wk), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata));
    // free running core clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait: 0 hf select, 1 rf ready, 2 aux clock; timeout ends the run
    task automatic wait_bit(input int which, input logic exp, input int bound);
        int n;
        logic s;
        n = 0;
        // look only once the launching edge has settled
        #1;
        s = (which == 0) ? hf : (which == 1) ? rdy : aux_clk;
        while (s !== exp && n < bound) begin
            @(posedge core_clk);
            #1;
            n++;
            s = (which == 0) ? hf : (which == 1) ? rdy : aux_clk;
        end
        compares++;
        if (s !== exp) begin
            miscompares++;
            $display("MISMATCH wait %0d expected %b seen %b", which, exp, s);
            wrap_up();
        end
    endtask
    // main enable alone brings up supplies, oscillator and crystal clock
    task automatic s_power_up();
        i_host.set_pin(0, 1'b1, GAP);
        wait_bit(0, 1'b1, 200);
        check("power", 8'h0f, pw_vec);
        i_host.read_reg(RPMRC_RSSI_OSC_ADDR, d);
        check("osc flag", 8'h40, d);
    endtask
    // six control codes with the 5 v supply and two without it, plus recovery times
    task automatic s_modes();
        logic [7:0] mv[8] = '{8'h01, 8'h03, 8'h21, 8'h31, 8'h81, 8'hb1, 8'h30, 8'h02};
        logic [7:0] me[8] = '{8'h01, 8'h05, 8'h0d, 8'h0f, 8'h01, 8'h01, 8'h0e, 8'h04};
        for (int i = 0; i < 8; i++) begin
            i_host.write_reg(RPMRC_CHIP_CTRL_ADDR, mv[i]);
            #1;
            check("rf", me[i], rf_vec);
            i_host.read_reg(RPMRC_CHIP_CTRL_ADDR, d);
            check("ctrl", mv[i], d);
        end
        i_host.write_reg(RPMRC_CHIP_CTRL_ADDR, 8'h81);
        i_host.write_reg(RPMRC_CHIP_CTRL_ADDR, 8'h21);
        #1;
        check("standby busy", 8'h00, {7'h00, rdy});
        wait_bit(1, 1'b1, 1001);
        i_host.write_reg(RPMRC_CHIP_CTRL_ADDR, 8'h01);
        i_host.write_reg(RPMRC_CHIP_CTRL_ADDR, 8'h21);
        #1;
        check("mode1 busy", 8'h00, {7'h00, rdy});
        wait_bit(1, 1'b1, 251);
    endtask
    // input steering: default and swapped, main and aux outputs both checked
    task automatic s_rx_swap();
        @(posedge core_clk);
        rx1 <= 1'b1;
        rx2 <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        check("rx default", 8'h02, rxd_vec);
        i_host.write_reg(RPMRC_CHIP_CTRL_ADDR, 8'h29);
        repeat (6) @(posedge core_clk);
        #1;
        check("rx swapped", 8'h01, rxd_vec);
    endtask
    // tag response stores both strengths beside the oscillator flag
    task automatic s_rssi();
        @(posedge core_clk);
        m_rssi <= 3'h5;
        a_rssi <= 3'h2;
        tag <= 1'b1;
        @(posedge core_clk);
        tag <= 1'b0;
        i_host.read_reg(RPMRC_RSSI_OSC_ADDR, d);
        check("rssi", 8'h55, d);
    endtask
    // filter and gain codes, reserved bits, protocol reload, refused accesses
    task automatic s_setting();
        logic [7:0] sv[3] = '{8'h9f, 8'h6b, 8'h07};
        for (int i = 0; i < 3; i++) begin
            i_host.write_reg(RPMRC_RX_SETTING_ADDR, sv[i]);
            i_host.read_reg(RPMRC_RX_SETTING_ADDR, d);
            check("setting", sv[i] & 8'hfc, d);
            check("filters", sv[i] & 8'hfc, flt_vec);
        end
        i_host.write_reg(RPMRC_PROTO_SEL_ADDR, 8'h0c);
        i_host.read_reg(RPMRC_RX_SETTING_ADDR, d);
        check("setting reload", 8'h40, d);
        i_host.write_reg(RPMRC_RSSI_OSC_ADDR, 8'h00);
        i_host.read_reg(RPMRC_RSSI_OSC_ADDR, d);
        check("status ro", 8'h55, d);
        i_host.read_reg(8'h33, d);
        check("unmapped", 8'h00, d);
    endtask
    // wake held high while main drops: sleep keeps supply and slow clock
    task automatic s_sleep();
        i_host.write_reg(RPMRC_RX_SETTING_ADDR, 8'h20);
        i_host.set_pin(1, 1'b1, GAP);
        i_host.set_pin(0, 1'b0, GAP);
        wait_bit(0, 1'b0, 20);
        check("sleep", 8'h02, pw_vec);
        check("sleep rf", 8'h00, {4'h0, tx, rx, 2'b00});
        wait_bit(2, 1'b1, 200);
        wait_bit(2, 1'b0, 200);
        i_host.read_reg(RPMRC_RSSI_OSC_ADDR, d);
        check("flag sleep", 8'h00, {7'h00, d[6]});
        i_host.read_reg(RPMRC_RX_SETTING_ADDR, d);
        check("setting off", 8'h40, d);
    endtask
    // wake edge from power down: timeout, then a confirmed wake
    task automatic s_wake();
        i_host.set_pin(1, 1'b0, GAP);
        repeat (10) @(posedge core_clk);
        #1;
        check("down", 8'h00, pw_vec);
        i_host.set_pin(1, 1'b1, GAP);
        wait_bit(0, 1'b1, 200);
        check("wake up", 8'h0f, pw_vec);
        repeat (900) @(posedge core_clk);
        #1;
        check("window", 8'h0f, pw_vec);
        wait_bit(0, 1'b0, 200);
        check("timed out", 8'h00, pw_vec);
        i_host.set_pin(1, 1'b0, GAP);
        // hold low long enough for the filter to see a new rising edge
        repeat (10) @(posedge core_clk);
        i_host.set_pin(1, 1'b1, GAP);
        wait_bit(0, 1'b1, 200);
        i_host.set_pin(0, 1'b1, 0);
        repeat (1200) @(posedge core_clk);
        #1;
        check("confirmed", 8'h0f, pw_vec);
    endtask
    // reset, then the scenarios in order
    initial begin
        reset_n = 1'b0;
        rx1 = 1'b0;
        rx2 = 1'b0;
        tag = 1'b0;
        m_rssi = 3'h0;
        a_rssi = 3'h0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        check("reset power", 8'h00, pw_vec);
        check("reset filters", 8'h40, flt_vec);
        check("reset supply", 8'h01, rf_vec);
        s_power_up();
        s_modes();
        s_rx_swap();
        s_rssi();
        s_setting();
        s_sleep();
        s_wake();
        wrap_up();
    end
endmodule // reader_power_mode_and_rx_config_bench
